//--- design/adcsp_dev.sv
// Functional notes
// - Mode low: device drives clock and receive frame
// - Mode high: host drives clock and frame
// - Trigger rise after pulse: hold, convert
// - Trigger during pulse: wait for pulse end
// - Capacitor sets settling pulse length
// - Master clock paces conversion and shift clock
// - Shift clock loads control, shifts results
// - Transmit frame active low, data after fall
// - Slave mode: host strobes receive frame
// - Master mode: device makes receive frame
// - Tie both frames for full duplex
// - Word: zero, three address, twelve result
// - Sixteen valid bits on falling edges
// - Bipolar two's complement, unipolar straight binary
// - First five bits load control, rest ignored
// - Channel bits pick multiplexer input
`timescale 1ns/100ps
`default_nettype none
module adcsp_dev
  import adcsp_pkg::*;
#(
  parameter int CAP_W = 8
)
(
  input  wire logic                i_clk,
  input  wire logic                i_sys_rst,
  adcsp_if.dev                     lnk,
  input  wire logic                i_conversion_trigger,
  input  wire logic [CAP_W-1:0]    i_pulse_timing_capacitor,
  input  wire logic                i_bipolar,
  input  wire logic [RES_BITS-1:0] i_sample,
  output logic      [CH_BITS-1:0]  o_multiplexer_output,
  output logic                     o_hold,
  output logic      [CTRL_BITS-1:0] o_ctrl,
  output logic                     o_result_valid
);
  //////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [4:0] pins_s;
  adcsp_sync #(.W(5), .RST_VAL(DEV_PIN_IDLE)) u_sync
  (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_d       ({lnk.mode, lnk.sclk, lnk.rfs_n, lnk.tfs_n, lnk.data_in}),
    .o_q       (pins_s)
  );
  logic trig_s1_r, trig_s2_r, trig_d_r;
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      trig_s1_r <= 1'b0;
      trig_s2_r <= 1'b0;
      trig_d_r  <= 1'b0;
    end
    else
    begin
      trig_s1_r <= i_conversion_trigger;
      trig_s2_r <= trig_s1_r;
      trig_d_r  <= trig_s2_r;
    end
  end
  wire trig_rise = trig_s2_r & ~trig_d_r;
  wire slave     = pins_s[4];
  //////////////////////////////////////////////////////////////////////////
  // Serial clock and frame selection
  logic sclk_r, sclk_d_r, rfs_m_r, tfs_d_r, rfs_d_r;
  logic [7:0] div_r;
  wire sclk_eff = slave ? pins_s[3] : sclk_r;
  wire rfs_eff  = slave ? pins_s[2] : rfs_m_r;
  wire sfall    = sclk_d_r & ~sclk_eff;
  wire srise    = ~sclk_d_r & sclk_eff;
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      div_r  <= 8'h00;
      sclk_r <= 1'b1;
    end
    else if (div_r == 8'(SCLK_DIV - 1))
    begin
      div_r  <= 8'h00;
      sclk_r <= ~sclk_r;
    end
    else
      div_r <= div_r + 8'h01;
  end
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      sclk_d_r <= 1'b1;
      tfs_d_r  <= 1'b1;
      rfs_d_r  <= 1'b1;
    end
    else
    begin
      sclk_d_r <= sclk_eff;
      tfs_d_r  <= pins_s[1];
      rfs_d_r  <= rfs_eff;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // Control register load
  logic [CTRL_BITS-1:0] ctrl_r;
  logic [2:0]           in_cnt_r;
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      ctrl_r   <= CTRL_RESET;
      in_cnt_r <= 3'h0;
    end
    else if (pins_s[1])
      in_cnt_r <= 3'h0;
    else if (tfs_d_r && !pins_s[1])
      in_cnt_r <= 3'h0;
    else if (sfall && in_cnt_r < 3'(CTRL_BITS))
    begin
      ctrl_r   <= {ctrl_r[CTRL_BITS-2:0], pins_s[0]};
      in_cnt_r <= in_cnt_r + 3'h1;
    end
  end
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_ctrl               <= CTRL_RESET;
      o_multiplexer_output <= 3'h0;
    end
    else
    begin
      o_ctrl               <= ctrl_r;
      o_multiplexer_output <= ctrl_r[CH_LSB +: CH_BITS];
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // Conversion sequencer
  adcsp_conv_type st_r;
  logic [15:0] pulse_r;
  logic [7:0]  conv_r;
  logic        pend_r;
  logic [RES_BITS-1:0] result_r;
  logic        word_rdy_r;
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      pulse_r <= 16'h0000;
    else if (ctrl_r != o_ctrl)
      pulse_r <= 16'(i_pulse_timing_capacitor) * 16'(SETTLE_PER_CAP);
    else if (pulse_r != 16'h0000)
      pulse_r <= pulse_r - 16'h0001;
  end
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      st_r           <= ADCSP_IDLE;
      conv_r         <= 8'h00;
      o_hold         <= 1'b0;
      result_r       <= '0;
      o_result_valid <= 1'b0;
      word_rdy_r     <= 1'b0;
    end
    else
    begin
      o_result_valid <= 1'b0;
      unique case (st_r)
        ADCSP_IDLE:
          if (trig_rise)
            st_r <= ADCSP_SETTLE;
        ADCSP_SETTLE:
          if (pulse_r == 16'h0000)
          begin
            st_r   <= ADCSP_CONV;
            o_hold <= 1'b1;
            conv_r <= 8'(CONV_CYCLES);
          end
        ADCSP_CONV:
          if (conv_r == 8'h01)
          begin
            st_r           <= ADCSP_IDLE;
            o_hold         <= 1'b0;
            result_r       <= i_bipolar ? (i_sample ^ BIPOLAR_FLIP)
                                        : i_sample;
            o_result_valid <= 1'b1;
            word_rdy_r     <= 1'b1;
          end
          else
            conv_r <= conv_r - 8'h01;
        default:
          st_r <= ADCSP_IDLE;
      endcase
      // A frame start outside conversion consumes the word, so no stale frame follows
      if (st_r != ADCSP_CONV && rfs_d_r && !rfs_eff)
        word_rdy_r <= 1'b0;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // Output shift
  logic [WORD_BITS-1:0] shreg_r;
  logic [4:0]           out_cnt_r;
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      rfs_m_r <= 1'b1;
    else if (!slave && rfs_m_r && word_rdy_r && srise)
      rfs_m_r <= 1'b0;
    else if (!rfs_m_r && out_cnt_r == 5'(WORD_BITS) && srise)
      rfs_m_r <= 1'b1;
  end
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      shreg_r   <= '0;
      out_cnt_r <= 5'h00;
      pend_r    <= 1'b0;
    end
    else if (rfs_d_r && !rfs_eff)
    begin
      shreg_r   <= {1'b0, ctrl_r[CH_LSB +: CH_BITS], result_r};
      out_cnt_r <= 5'h00;
      pend_r    <= 1'b1;
    end
    else if (!rfs_eff && srise && !pend_r)
    begin
      shreg_r   <= {shreg_r[WORD_BITS-2:0], 1'b0};
    end
    else if (!rfs_eff && sfall && out_cnt_r < 5'(WORD_BITS))
    begin
      out_cnt_r <= out_cnt_r + 5'h01;
      pend_r    <= 1'b0;
    end
  end
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      lnk.sclk_dev     <= 1'b1;
      lnk.sclk_dev_oe  <= 1'b0;
      lnk.rfs_n_dev    <= 1'b1;
      lnk.rfs_n_dev_oe <= 1'b0;
      lnk.data_out     <= 1'b0;
    end
    else
    begin
      // Shift clock rests high outside a frame
      lnk.sclk_dev     <= sclk_r | rfs_m_r;
      lnk.sclk_dev_oe  <= ~slave;
      lnk.rfs_n_dev    <= rfs_m_r;
      lnk.rfs_n_dev_oe <= ~slave;
      lnk.data_out     <= shreg_r[WORD_BITS-1];
    end
  end
endmodule : adcsp_dev
`default_nettype wire

//--- design/adcsp_host.sv
`timescale 1ns/100ps
`default_nettype none
module adcsp_host
  import adcsp_pkg::*;
(
  input  wire logic                 i_clk,
  input  wire logic                 i_sys_rst,
  adcsp_if.host                     lnk,
  input  wire logic                 i_start,
  input  wire logic [CTRL_BITS-1:0] i_ctrl,
  output logic                      o_busy,
  output logic      [WORD_BITS-1:0] o_word,
  output logic                      o_word_valid
);
  logic [3:0] s_s;
  adcsp_sync #(.W(4), .RST_VAL(HOST_PIN_IDLE)) u_sync
  (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_d       ({lnk.mode, lnk.rfs_n, lnk.sclk, lnk.data_out}),
    .o_q       (s_s)
  );
  logic sclk_q_r;
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      sclk_q_r <= 1'b1;
    else
      sclk_q_r <= s_s[1];
  end
  logic [CTRL_BITS-1:0] tx_r;
  logic [WORD_BITS-1:0] rx_r;
  logic [5:0] ph_r;
  logic [2:0] div_r;
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_busy <= 1'b0;
      ph_r <= 6'h00;
      div_r <= 3'h0;
      tx_r <= '0;
      rx_r <= '0;
      o_word <= '0;
      o_word_valid <= 1'b0;
      lnk.sclk_host <= 1'b1;
      lnk.rfs_n_host <= 1'b1;
      lnk.tfs_n <= 1'b1;
      lnk.data_in <= 1'b0;
    end
    else
    begin
      o_word_valid <= 1'b0;
      if (!o_busy && i_start)
      begin
        o_busy <= 1'b1;
        tx_r <= i_ctrl;
        ph_r <= 6'h00;
        div_r <= 3'h0;
        lnk.tfs_n <= 1'b0;
        lnk.rfs_n_host <= 1'b0;
        lnk.data_in <= i_ctrl[CTRL_BITS-1];
      end
      else if (o_busy)
      begin
        div_r <= div_r + 3'h1;
        if (div_r == 3'h3)
          lnk.sclk_host <= 1'b0;
        else if (div_r == 3'h7)
        begin
          // Synced data lags, so the bit is taken mid-cell at the rise
          lnk.sclk_host <= 1'b1;
          ph_r <= ph_r + 6'h01;
          tx_r <= {tx_r[CTRL_BITS-2:0], 1'b0};
          lnk.data_in <= tx_r[CTRL_BITS-2];
          rx_r <= {rx_r[WORD_BITS-2:0], s_s[0]};
          if (ph_r == 6'(WORD_BITS - 1))
          begin
            o_busy <= 1'b0;
            lnk.tfs_n <= 1'b1;
            lnk.rfs_n_host <= 1'b1;
            o_word <= {rx_r[WORD_BITS-2:0], s_s[0]};
            o_word_valid <= 1'b1;
          end
        end
      end
      else if (!s_s[3])
      begin
        // Master mode: one bit on each synced clock fall in the frame
        if (s_s[2])
          ph_r <= 6'h00;
        else if (sclk_q_r && !s_s[1])
        begin
          ph_r <= ph_r + 6'h01;
          rx_r <= {rx_r[WORD_BITS-2:0], s_s[0]};
          if (ph_r == 6'(WORD_BITS - 1))
          begin
            o_word       <= {rx_r[WORD_BITS-2:0], s_s[0]};
            o_word_valid <= 1'b1;
          end
        end
      end
    end
  end
endmodule : adcsp_host
`default_nettype wire

//--- design/adcsp_sync.sv
`timescale 1ns/100ps
`default_nettype none
module adcsp_sync
  import adcsp_pkg::*;
#(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
)
(
  input  wire logic         i_clk,
  input  wire logic         i_sys_rst,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta_r;
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      meta_r <= RST_VAL;
      o_q    <= RST_VAL;
    end
    else
    begin
      meta_r <= i_d;
      o_q    <= meta_r;
    end
  end
endmodule : adcsp_sync
`default_nettype wire

//--- shared/adcsp_if.sv
`timescale 1ns/100ps
`default_nettype none
interface adcsp_if;
  logic sclk_host;
  logic sclk_dev;
  logic sclk_dev_oe;
  logic rfs_n_host;
  logic rfs_n_dev;
  logic rfs_n_dev_oe;
  logic tfs_n;
  logic data_in;
  logic data_out;
  logic mode;
  wire  sclk  = sclk_dev_oe ? sclk_dev : sclk_host;
  wire  rfs_n = rfs_n_dev_oe ? rfs_n_dev : rfs_n_host;
  modport dev
  (
    input  sclk, rfs_n, tfs_n, data_in, mode,
    output sclk_dev, sclk_dev_oe, rfs_n_dev, rfs_n_dev_oe, data_out
  );
  modport host
  (
    input  sclk, rfs_n, data_out, mode,
    output sclk_host, rfs_n_host, tfs_n, data_in
  );
endinterface : adcsp_if
`default_nettype wire

//--- shared/adcsp_pkg.sv
package adcsp_pkg;
  localparam int CTRL_BITS   = 5;
  localparam int WORD_BITS   = 16;
  localparam int RES_BITS    = 12;
  localparam int CH_BITS     = 3;
  localparam int CH_LSB      = 0;
  localparam int CONV_CYCLES = 59;
  localparam int SCLK_DIV    = 2;
  localparam int SETTLE_PER_CAP = 4;
  localparam logic [4:0] DEV_PIN_IDLE  = 5'h1e;
  localparam logic [3:0] HOST_PIN_IDLE = 4'he;
  localparam logic [CTRL_BITS-1:0] CTRL_RESET = 5'h00;
  localparam logic [11:0] BIPOLAR_FLIP = 12'h800;
  typedef enum logic [1:0]
  {
    ADCSP_IDLE   = 2'b00,
    ADCSP_SETTLE = 2'b01,
    ADCSP_CONV   = 2'b11
  } adcsp_conv_type;
endpackage : adcsp_pkg

//--- tb/adc_serial_port_convert_ctl_tb.sv
`timescale 1ns/100ps
`default_nettype none
module adc_serial_port_convert_ctl_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        trig = 1'b0;
  logic        bip = 1'b0;
  logic        start = 1'b0;
  logic [7:0]  cap = 8'h02;
  logic [11:0] samp = 12'h000;
  logic [4:0]  ctrl = 5'h00;
  logic        hold, rvalid, busy, wvalid;
  logic [4:0]  dctrl;
  logic [2:0]  mux;
  logic [15:0] word, exp_w;
  int          err_total, samples_checked, k, d, n;
  logic [4:0]  ctl_tab [4] = '{5'h15, 5'h0b, 5'h07, 5'h18};
  logic [7:0]  cap_tab [4] = '{8'h02, 8'h64, 8'h02, 8'h64};
  logic        bip_tab [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  logic [11:0] smp_tab [4] = '{12'habc, 12'h123, 12'h9f0, 12'h5a3};
  adcsp_if lnk ();
  adcsp_dev i_adcsp_dev
  (
    .i_clk                    (clk),
    .i_sys_rst                (rst),
    .lnk                      (lnk),
    .i_conversion_trigger     (trig),
    .i_pulse_timing_capacitor (cap),
    .i_bipolar                (bip),
    .i_sample                 (samp),
    .o_multiplexer_output     (mux),
    .o_hold                   (hold),
    .o_ctrl                   (dctrl),
    .o_result_valid           (rvalid)
  );
  adcsp_host i_adcsp_host
  (
    .i_clk        (clk),
    .i_sys_rst    (rst),
    .lnk          (lnk),
    .i_start      (start),
    .i_ctrl       (ctrl),
    .o_busy       (busy),
    .o_word       (word),
    .o_word_valid (wvalid)
  );
  adcsp_sva i_adcsp_sva
  (
    .i_clk        (clk),
    .i_sys_rst    (rst),
    .mode         (lnk.mode),
    .sclk         (lnk.sclk),
    .sclk_dev_oe  (lnk.sclk_dev_oe),
    .rfs_n        (lnk.rfs_n),
    .rfs_n_dev_oe (lnk.rfs_n_dev_oe),
    .rfs_n_host   (lnk.rfs_n_host),
    .tfs_n        (lnk.tfs_n),
    .data_out     (lnk.data_out)
  );
  always #50 clk = ~clk;
  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] got, input logic [15:0] want);
    samples_checked++;
    if (got !== want)
    begin
      err_total++;
      $display("mismatch at %0t: got %h want %h", $time, got, want);
    end
  endtask : check
  task automatic xfer(input logic [4:0] c);
    for (n = 0; n < 400 && busy !== 1'b0; n++)
      @(negedge clk);
    start = 1'b1;
    ctrl  = c;
    @(negedge clk);
    start = 1'b0;
    for (n = 0; n < 400 && wvalid !== 1'b1; n++)
      @(negedge clk);
  endtask : xfer
  task automatic conv;
    trig = 1'b1;
    for (d = 0; d < 600 && hold !== 1'b1; d++)
      @(negedge clk);
    for (n = 0; n < 200 && rvalid !== 1'b1; n++)
      @(negedge clk);
    trig = 1'b0;
    @(negedge clk);
  endtask : conv
  task automatic close_out;
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    lnk.mode = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    for (k = 0; k < 4; k++)
    begin
      cap   = cap_tab[k];
      bip   = bip_tab[k];
      samp  = smp_tab[k];
      exp_w = {1'b0, ctl_tab[k][2:0], samp ^ (bip ? 12'h800 : 12'h000)};
      xfer(ctl_tab[k]);
      check({11'h000, dctrl}, {11'h000, ctl_tab[k]});
      check({13'h0000, mux}, {13'h0000, ctl_tab[k][2:0]});
      conv();
      check({15'h0000, d > 100}, {15'h0000, cap > 8'h0a});
      xfer(ctl_tab[k]);
      check(word, exp_w);
      $display("test %0d done", k);
    end
    lnk.mode = 1'b0;
    samp     = 12'h3c6;
    bip      = 1'b1;
    exp_w    = {1'b0, ctl_tab[3][2:0], 12'h3c6 ^ 12'h800};
    repeat (5) @(negedge clk);
    conv();
    for (n = 0; n < 400 && wvalid !== 1'b1; n++)
      @(negedge clk);
    check(word, exp_w);
    $display("test master done");
    close_out();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    $display("mismatch at %0t: watchdog expired", $time);
    close_out();
  end
endmodule : adc_serial_port_convert_ctl_tb
`default_nettype wire

//--- tb/adcsp_sva.sv
`timescale 1ns/100ps
`default_nettype none
module adcsp_sva
(
  input wire logic       i_clk,
  input wire logic       i_sys_rst,
  input wire logic       mode,
  input wire logic       sclk,
  input wire logic       sclk_dev_oe,
  input wire logic       rfs_n,
  input wire logic       rfs_n_dev_oe,
  input wire logic       rfs_n_host,
  input wire logic       tfs_n,
  input wire logic       data_out
);
  logic [4:0] fall_cnt;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  //////////////////////////////////////////////////////////////////////////
  // Shift clock falls seen inside a receive frame
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || rfs_n)
      fall_cnt <= 5'h00;
    else if ($fell(sclk))
      fall_cnt <= fall_cnt + 5'h01;
  end
  //////////////////////////////////////////////////////////////////////////
  a_oe_master:
    assert property (!mode [*5] |-> sclk_dev_oe && rfs_n_dev_oe)
    else $error("device not driving clock and frame");
  a_oe_slave:
    assert property (mode [*5] |-> !sclk_dev_oe && !rfs_n_dev_oe)
    else $error("device drives pins in slave mode");
  a_sclk_toggle:
    assert property (sclk_dev_oe && !rfs_n && $past(rfs_n) == 1'b0
                     && $changed(sclk)
                     |-> ##2 ($changed(sclk) || rfs_n))
    else $error("master shift clock not divided from clock");
  a_frame_len:
    assert property ($rose(rfs_n) |-> fall_cnt == 5'h10)
    else $error("frame without sixteen clock falls");
  a_lead_zero:
    assert property ($fell(sclk) && !rfs_n && fall_cnt == 5'h00
                     |-> !data_out)
    else $error("first output bit not zero");
  a_out_steady:
    assert property (!sclk && $past(sclk) == 1'b0 && !rfs_n
                     |-> $stable(data_out))
    else $error("output bit moved while clock low");
  a_frames_tied:
    assert property (mode && !rfs_n_dev_oe |-> tfs_n == rfs_n_host)
    else $error("transmit and receive frames differ");
  a_clk_still:
    assert property (rfs_n [*4] |-> $stable(sclk))
    else $error("shift clock moves outside frame");
endmodule : adcsp_sva
`default_nettype wire
